// ==== logic/drive_protection_options.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_protection_options
  import drive_protection_pkg::*;
#(
  parameter int FAN_SPIN_CYC = FAN_SPINUP_CYC,
  parameter logic [CNT_W-1:0] FACTORY_THR = CAP_FACTORY_THR
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_run_cmd,
  input wire sense_t i_sense,
  output logic o_drive_en,
  output logic o_fan_run,
  output logic o_carrier_low,
  output alarm_t o_alarm,
  output logic o_overheat_warning_output,
  output logic o_life_warning,
  output logic o_cap_life_end
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [OPT_W-1:0] protection_option_word_q;
  logic [OPT_W-1:0] hold_q;
  logic fan_onoff_control_q;
  logic [CNT_W-1:0] thresh_q;
  logic wr_opt;
  logic wr_ctrl;
  logic alarm_clr;

  assign wr_opt = i_wr && i_addr == ADDR_OPTION;
  assign wr_ctrl = i_wr && i_addr == ADDR_CTRL;
  assign alarm_clr = wr_ctrl && i_wdata[CTRL_ALARM_CLR];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      protection_option_word_q <= OPTION_RST;
    end else if (i_ce && wr_opt) begin
      // bits above the word are dropped, weights stay binary
      protection_option_word_q <= i_wdata[OPT_W-1:0];
    end
  end

  // paths never see a word that is half written
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= OPTION_RST;
    end else if (i_ce) begin
      hold_q <= protection_option_word_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fan_onoff_control_q <= FAN_ONOFF_RST;
      thresh_q <= THRESH_RST;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        fan_onoff_control_q <= i_wdata[CTRL_FAN_ONOFF];
      end
      if (i_wr && i_addr == ADDR_THRESH) begin
        thresh_q <= i_wdata[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded enables
  // ----------------------------------------------------------------
  logic en_carrier;
  logic en_in_phase;
  logic en_out_phase;
  logic fan_continue;

  assign en_carrier = opt_bit(hold_q, BIT_CARRIER);
  assign en_in_phase = opt_bit(hold_q, BIT_IN_PHASE);
  assign en_out_phase = opt_bit(hold_q, BIT_OUT_PHASE);
  assign fan_continue = opt_bit(hold_q, BIT_FAN_CONT);

  // ----------------------------------------------------------------
  // run sequencing
  // ----------------------------------------------------------------
  run_state_t st_q;
  run_state_t st_d;
  logic [15:0] spin_q;
  logic spin_done;
  alarm_t alarm_q;
  alarm_t ev;
  logic any_alarm;
  logic lock_ev;
  logic fan_chk;
  logic partial_loss;

  assign spin_done = spin_q == 16'(FAN_SPIN_CYC - 1);
  assign any_alarm = |alarm_q;

  // lock only counts while the fan is meant to turn and is up to speed
  assign fan_chk = o_fan_run && st_q != ST_FAN_START;
  assign lock_ev = i_sense.fan_locked && fan_chk;

  // a contactor opening kills every phase at once; not a fault
  assign partial_loss = i_sense.out_phase_present != 3'h7
    && i_sense.out_phase_present != 3'h0;

  always_comb begin
    ev.output_phase_loss_alarm = en_out_phase && st_q == ST_RUN
      && partial_loss;
    ev.in_phase_loss_alarm = en_in_phase && st_q == ST_RUN
      && i_sense.in_phase_fault;
    ev.heatsink_overheat_alarm = (lock_ev && !fan_continue)
      || (st_q == ST_RUN && i_sense.heat_or_overload && !en_carrier);
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (i_run_cmd && !any_alarm && !(|ev)) begin
          st_d = fan_onoff_control_q ? ST_FAN_START : ST_RUN;
        end
      end
      ST_FAN_START: begin
        if (|ev) begin
          st_d = ST_TRIP;
        end else if (!i_run_cmd) begin
          st_d = ST_IDLE;
        end else if (spin_done) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (|ev) begin
          st_d = ST_TRIP;
        end else if (!i_run_cmd) begin
          st_d = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (!any_alarm) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ST_IDLE;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      spin_q <= 16'h0000;
    end else if (i_ce) begin
      if (st_q == ST_FAN_START && !spin_done) begin
        spin_q <= spin_q + 16'h0001;
      end else begin
        spin_q <= 16'h0000;
      end
    end
  end

  // drive removal lets the motor coast
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_drive_en <= 1'b0;
    end else if (i_ce) begin
      o_drive_en <= st_d == ST_RUN;
    end
  end

  // fan stops by command only when on/off control is enabled
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fan_run <= 1'b1;
    end else if (i_ce) begin
      o_fan_run <= !fan_onoff_control_q
        || st_d == ST_FAN_START || st_d == ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // alarms, warnings, carrier
  // ----------------------------------------------------------------
  // a new event beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alarm_q <= '0;
    end else if (i_ce) begin
      alarm_q <= (alarm_clr ? '0 : alarm_q) | ev;
    end
  end

  assign o_alarm = alarm_q;

  logic life_end;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_overheat_warning_output <= 1'b0;
      o_life_warning <= 1'b0;
    end else if (i_ce) begin
      // warnings follow the lock, whichever handling is chosen
      o_overheat_warning_output <= lock_ev;
      o_life_warning <= lock_ev || life_end;
    end
  end

  // lowering costs motor noise, accepted for keeping the load running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_carrier_low <= 1'b0;
    end else if (i_ce) begin
      o_carrier_low <= en_carrier && st_q == ST_RUN
        && i_sense.heat_or_overload;
    end
  end

  cap_life_judge #(
    .FACTORY_THR(FACTORY_THR)
  ) u_cap_life (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_judge_en(opt_bit(hold_q, BIT_CAP_LIFE)),
    .i_user_sel(opt_bit(hold_q, BIT_THR_SEL)),
    .i_user_thr(thresh_q),
    .i_power_lost(i_sense.power_lost),
    .i_dc_discharged(i_sense.dc_discharged),
    .o_life_end(life_end)
  );

  assign o_cap_life_end = life_end;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status;

  always_comb begin
    status = '0;
    status[STAT_OUT_LOSS] = alarm_q.output_phase_loss_alarm;
    status[STAT_IN_LOSS] = alarm_q.in_phase_loss_alarm;
    status[STAT_HEATSINK] = alarm_q.heatsink_overheat_alarm;
    status[STAT_WARN_HEAT] = o_overheat_warning_output;
    status[STAT_WARN_LIFE] = o_life_warning;
    status[STAT_CAP_END] = life_end;
    status[STAT_DRIVE] = o_drive_en;
    status[STAT_FAN] = o_fan_run;
    status[STAT_CARRIER] = o_carrier_low;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        unique case (i_addr)
          ADDR_OPTION: o_rdata <= DATA_W'(protection_option_word_q);
          ADDR_CTRL: o_rdata <= DATA_W'(fan_onoff_control_q);
          ADDR_THRESH: o_rdata <= thresh_q;
          ADDR_STATUS: o_rdata <= status;
          default: o_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence fan_start_s;
    st_q == ST_IDLE && i_run_cmd && fan_onoff_control_q && !any_alarm
      && !(|ev) && i_ce;
  endsequence

  sequence spun_up_s;
    st_q == ST_FAN_START && spin_done && i_run_cmd && !(|ev) && i_ce;
  endsequence

  outloss_trip_a: assert property (
    (i_ce && st_q == ST_RUN && en_out_phase && partial_loss)
    |=> o_alarm.output_phase_loss_alarm && !o_drive_en)
    else $error("output phase loss did not trip");

  allphase_quiet_a: assert property (
    (i_ce && st_q == ST_RUN && i_sense.out_phase_present == 3'h0)
    |=> !o_alarm.output_phase_loss_alarm)
    else $error("all-phase loss reported");

  lock_alarm_a: assert property (
    (i_ce && lock_ev && !fan_continue)
    |=> o_alarm.heatsink_overheat_alarm && !o_drive_en)
    else $error("fan lock alarm missing");

  lock_run_a: assert property (
    (i_ce && st_q == ST_RUN && lock_ev && fan_continue && i_run_cmd
      && !(|ev))
    |=> o_drive_en && !o_alarm.heatsink_overheat_alarm)
    else $error("fan lock stopped drive");

  lock_warn_a: assert property (
    (i_ce && lock_ev) |=> o_overheat_warning_output && o_life_warning)
    else $error("fan lock warnings missing");

  stopped_quiet_a: assert property (
    (i_ce && !o_fan_run) |=> !o_overheat_warning_output)
    else $error("lock seen on stopped fan");

  fan_first_a: assert property (
    fan_start_s |=> o_fan_run && !o_drive_en)
    else $error("drive before fan command");

  spin_run_a: assert property (
    spun_up_s |=> o_drive_en && o_fan_run)
    else $error("no drive after spin-up");

  hold_copy_a: assert property (
    (i_ce && wr_opt) ##1 i_ce |=> hold_q == $past(i_wdata[OPT_W-1:0], 2))
    else $error("option word not held");

  carrier_low_a: assert property (
    (i_ce && st_q == ST_RUN && en_carrier && i_sense.heat_or_overload
      && !i_sense.fan_locked && !partial_loss && !i_sense.in_phase_fault
      && i_run_cmd)
    |=> o_carrier_low && o_drive_en)
    else $error("carrier not lowered");

  heat_trip_a: assert property (
    (i_ce && st_q == ST_RUN && !en_carrier && i_sense.heat_or_overload)
    |=> o_alarm.heatsink_overheat_alarm && !o_carrier_low)
    else $error("overload did not trip");

  inloss_trip_a: assert property (
    (i_ce && st_q == ST_RUN && en_in_phase && i_sense.in_phase_fault)
    |=> o_alarm.in_phase_loss_alarm && !o_drive_en)
    else $error("input phase loss did not trip");

endmodule
`default_nettype wire

// ==== logic/drive_protection_pkg.sv ====
package drive_protection_pkg;

  // ----------------------------------------------------------------
  // bus and option word geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int OPT_W = 6;
  localparam int CNT_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_OPTION = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

  // ----------------------------------------------------------------
  // option word fields
  // ----------------------------------------------------------------
  localparam int BIT_CARRIER = 0;
  localparam int BIT_IN_PHASE = 1;
  localparam int BIT_OUT_PHASE = 2;
  localparam int BIT_THR_SEL = 3;
  localparam int BIT_CAP_LIFE = 4;
  localparam int BIT_FAN_CONT = 5;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_FAN_ONOFF = 0;
  localparam int CTRL_ALARM_CLR = 1;

  localparam int STAT_OUT_LOSS = 0;
  localparam int STAT_IN_LOSS = 1;
  localparam int STAT_HEATSINK = 2;
  localparam int STAT_WARN_HEAT = 3;
  localparam int STAT_WARN_LIFE = 4;
  localparam int STAT_CAP_END = 5;
  localparam int STAT_DRIVE = 6;
  localparam int STAT_FAN = 7;
  localparam int STAT_CARRIER = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [OPT_W-1:0] OPTION_RST = 6'h00;
  localparam logic FAN_ONOFF_RST = 1'b0;
  localparam logic [CNT_W-1:0] THRESH_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CAP_FACTORY_THR = 16'h0800;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAN_SPINUP_US = 100;
  localparam int FAN_SPINUP_CYC =
    (FAN_SPINUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] out_phase_present;
    logic in_phase_fault;
    logic heat_or_overload;
    logic fan_locked;
    logic power_lost;
    logic dc_discharged;
  } sense_t;

  typedef struct packed {
    logic heatsink_overheat_alarm;
    logic in_phase_loss_alarm;
    logic output_phase_loss_alarm;
  } alarm_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FAN_START = 4'b0010,
    ST_RUN = 4'b0100,
    ST_TRIP = 4'b1000
  } run_state_t;

  function automatic logic opt_bit(input logic [OPT_W-1:0] w, input int pos);
    opt_bit = w[pos];
  endfunction

endpackage

// ==== logic/cap_life_judge.sv ====
`timescale 1ns/1ps
`default_nettype none
module cap_life_judge
  import drive_protection_pkg::*;
#(
  parameter logic [CNT_W-1:0] FACTORY_THR = CAP_FACTORY_THR
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_judge_en,
  input wire logic i_user_sel,
  input wire logic [CNT_W-1:0] i_user_thr,
  input wire logic i_power_lost,
  input wire logic i_dc_discharged,
  output logic o_life_end
);

  logic lost_prev_q;
  logic meas_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] thr;

  // shrinking capacitance discharges faster than the threshold
  assign thr = i_user_sel ? i_user_thr : FACTORY_THR;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lost_prev_q <= 1'b0;
      meas_q <= 1'b0;
      cnt_q <= '0;
    end else if (i_ce) begin
      lost_prev_q <= i_power_lost;
      if (i_power_lost && !lost_prev_q && i_judge_en) begin
        meas_q <= 1'b1;
        cnt_q <= '0;
      end else if (meas_q && i_dc_discharged) begin
        meas_q <= 1'b0;
      end else if (meas_q && cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_life_end <= 1'b0;
    end else if (i_ce) begin
      if (!i_judge_en) begin
        o_life_end <= 1'b0;
      end else if (meas_q && i_dc_discharged) begin
        o_life_end <= cnt_q < thr;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  judge_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!i_judge_en && i_ce) |=> !o_life_end)
    else $error("life end shown while judgment disabled");

  factory_thr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_judge_en && !i_user_sel && meas_q && i_dc_discharged)
    |=> o_life_end == ($past(cnt_q) < FACTORY_THR))
    else $error("factory threshold not applied");

  user_thr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_judge_en && i_user_sel && meas_q && i_dc_discharged)
    |=> o_life_end == ($past(cnt_q) < $past(i_user_thr)))
    else $error("user threshold not applied");

endmodule
`default_nettype wire

// ==== bench/power_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
  import drive_protection_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_drive_en,
  input wire logic i_fan_run,
  input wire logic [2:0] i_phase_cut,
  input wire logic i_in_fault,
  input wire logic i_heat,
  input wire logic i_fan_broken,
  input wire logic i_power_off,
  input wire logic [CNT_W-1:0] i_discharge_cyc,
  output sense_t o_sense
);
  // ------------------------------------------------------------
  // dc link discharge timer
  // ------------------------------------------------------------
  logic [CNT_W-1:0] dis_cnt_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dis_cnt_q <= '0;
    end else if (!i_power_off) begin
      dis_cnt_q <= '0;
    end else if (dis_cnt_q != i_discharge_cyc) begin
      dis_cnt_q <= dis_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // sensing
  // ------------------------------------------------------------
  always_comb begin
    // an undriven bridge shows no output phases at all
    o_sense.out_phase_present = i_drive_en ? ~i_phase_cut : 3'h0;
    o_sense.in_phase_fault = i_in_fault;
    o_sense.heat_or_overload = i_heat;
    // a fan stopped by command looks exactly like a locked one
    o_sense.fan_locked = i_fan_run ? i_fan_broken : 1'b1;
    o_sense.power_lost = i_power_off;
    o_sense.dc_discharged = i_power_off && (dis_cnt_q == i_discharge_cyc);
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import drive_protection_pkg::*;
  // ------------------------------------------------------------
  // setup
  // ------------------------------------------------------------
  localparam int SPIN = 4;
  localparam logic [CNT_W-1:0] FTHR = 16'h0040;
  localparam logic [15:0] FAN = 16'h0001 << STAT_FAN;
  localparam logic [15:0] DRV = 16'h0001 << STAT_DRIVE;
  localparam logic [15:0] CAR = 16'h0001 << STAT_CARRIER;
  localparam logic [15:0] AH = 16'h0001 << STAT_HEATSINK;
  localparam logic [15:0] AI = 16'h0001 << STAT_IN_LOSS;
  localparam logic [15:0] AO = 16'h0001 << STAT_OUT_LOSS;
  localparam logic [15:0] WHL = (16'h0001 << STAT_WARN_HEAT) | (16'h0001 << STAT_WARN_LIFE);
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_ce = 1'b1;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_run_cmd = 1'b0;
  logic [4:0] flt = 5'h00;
  logic pwr_off = 1'b0;
  logic [CNT_W-1:0] dis_cyc = 16'h0001;
  logic [DATA_W-1:0] o_rdata;
  sense_t i_sense;
  alarm_t o_alarm;
  logic o_drive_en, o_fan_run, o_carrier_low, o_overheat_warning_output;
  logic o_life_warning, o_cap_life_end;
  logic [15:0] pv;
  int miscompares = 0;
  int checks = 0;

  always #20 i_clk = ~i_clk;

  drive_protection_options #(.FAN_SPIN_CYC(SPIN), .FACTORY_THR(FTHR)) i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_run_cmd(i_run_cmd), .i_sense(i_sense), .o_drive_en(o_drive_en),
    .o_fan_run(o_fan_run), .o_carrier_low(o_carrier_low), .o_alarm(o_alarm),
    .o_overheat_warning_output(o_overheat_warning_output),
    .o_life_warning(o_life_warning), .o_cap_life_end(o_cap_life_end));

  power_stage_model model (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_drive_en(o_drive_en),
    .i_fan_run(o_fan_run), .i_phase_cut(flt[3] ? 3'b111 : {2'b00, flt[2]}),
    .i_in_fault(flt[1]), .i_heat(flt[0]), .i_fan_broken(flt[4]),
    .i_power_off(pwr_off), .i_discharge_cyc(dis_cyc), .o_sense(i_sense));

  // port view laid out like the status register
  assign pv = {7'h00, o_carrier_low, o_fan_run, o_drive_en, o_cap_life_end,
    o_life_warning, o_overheat_warning_output, o_alarm};

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string msg);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, msg);
  endtask

  task automatic expect_state(input logic [15:0] exp, input string msg);
    chk(pv, exp, msg);
    rchk(ADDR_STATUS, exp, msg);
  endtask

  task automatic fault_case(input logic [5:0] opt, input logic [4:0] f, input logic [15:0] exp);
    wr(ADDR_OPTION, {10'h000, opt});
    @(posedge i_clk);
    i_run_cmd <= 1'b1;
    cyc(4);
    expect_state(DRV | FAN, "running");
    @(posedge i_clk);
    flt <= f;
    cyc(4);
    expect_state(exp, "under fault");
    @(posedge i_clk);
    flt <= 5'h00;
    i_run_cmd <= 1'b0;
    wr(ADDR_CTRL, 16'h0002);
    cyc(4);
    expect_state(FAN, "recovered");
  endtask

  // measured in idle with nothing else loading the link
  task automatic cap_case(input logic [5:0] opt, input logic [15:0] dis, input logic exp);
    wr(ADDR_OPTION, {10'h000, opt});
    @(posedge i_clk);
    dis_cyc <= dis;
    pwr_off <= 1'b1;
    cyc(int'(dis) + 6);
    chk(16'({o_cap_life_end, o_life_warning}), 16'({exp, exp}), "life end");
    @(posedge i_clk);
    pwr_off <= 1'b0;
    cyc(4);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #(40 * 20000);
    $display("[FAIL] t=%0t watchdog expired", $time);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    cyc(2);
    expect_state(FAN, "reset state");
    rchk(ADDR_OPTION, 16'h0000, "option reset");
    rchk(ADDR_CTRL, 16'h0000, "ctrl reset");
    rchk(ADDR_THRESH, 16'h0000, "thresh reset");
    wr(4'h5, 16'hffff);
    rchk(4'h5, 16'h0000, "unmapped");
    wr(ADDR_THRESH, 16'h00c8);
    rchk(ADDR_THRESH, 16'h00c8, "thresh rw");
    wr(ADDR_CTRL, 16'h0003);
    rchk(ADDR_CTRL, 16'h0001, "clear bit reads 0");
    wr(ADDR_CTRL, 16'h0000);
    $display("test registers done");
    for (int v = 0; v < 64; v++) begin
      wr(ADDR_OPTION, 16'hffc0 | 16'(v));
      rchk(ADDR_OPTION, 16'(v), "option word");
    end
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(ADDR_OPTION, 16'h0000);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rchk(ADDR_OPTION, 16'h003f, "ce low ignored");
    $display("test option word done");
    fault_case(6'h01, 5'h01, DRV | FAN | CAR);
    fault_case(6'h00, 5'h01, FAN | AH);
    fault_case(6'h00, 5'h02, DRV | FAN);
    fault_case(6'h02, 5'h02, FAN | AI);
    fault_case(6'h04, 5'h04, FAN | AO);
    fault_case(6'h00, 5'h04, DRV | FAN);
    fault_case(6'h04, 5'h08, DRV | FAN);
    fault_case(6'h00, 5'h10, FAN | AH | WHL);
    fault_case(6'h20, 5'h10, DRV | FAN | WHL);
    $display("test protections done");
    wr(ADDR_OPTION, 16'h0020);
    wr(ADDR_CTRL, 16'h0001);
    @(posedge i_clk);
    flt <= 5'h10;
    cyc(4);
    expect_state(16'h0000, "fan stopped idle");
    @(posedge i_clk);
    i_run_cmd <= 1'b1;
    cyc(2);
    chk(pv, FAN, "fan spin-up");
    cyc(SPIN + 4);
    expect_state(DRV | FAN | WHL, "lock after start");
    @(posedge i_clk);
    i_run_cmd <= 1'b0;
    flt <= 5'h00;
    wr(ADDR_CTRL, 16'h0000);
    cyc(4);
    $display("test fan control done");
    cap_case(6'h10, 16'h0014, 1'b1);
    cap_case(6'h10, 16'h0064, 1'b0);
    cap_case(6'h18, 16'h0064, 1'b1);
    cap_case(6'h18, 16'h00dc, 1'b0);
    cap_case(6'h00, 16'h0014, 1'b0);
    $display("test capacitor done");
    report_and_stop();
  end
endmodule
`default_nettype wire
